// ===== verilog/ocddc_pkg.sv
/*
  Constants, register map and carrier types for the on-chip debug control block.
  Assumes a 50 MHz APB clock and a processor core that reports decoded opcodes
  and its program counter on the same clock.
*/
//==========================================================================
package ocddc_pkg;

  //==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_COUNTER = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;

  //==========================================================================
  // Control register fields
  localparam int         BIT_HALT     = 7;
  localparam int         BIT_BRK_EN   = 6;
  localparam int         BIT_ACK_EN   = 5;
  localparam int         BIT_LOOP_SEL = 4;
  localparam int         BIT_PC_MATCH = 3;
  localparam int         BIT_ZERO_CNT = 2;
  localparam int         BIT_RST      = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;

  // Status register fields
  localparam int         STS_HALT     = 0;
  localparam int         STS_LOOP     = 1;
  localparam int         STS_ACK      = 2;
  localparam int         STS_RST      = 3;

  //==========================================================================
  // Opcodes, characters and widths
  localparam logic [7:0] BRK_OPCODE   = 8'h00;
  localparam logic [7:0] ACK_CHAR     = 8'hFF;
  localparam int         PC_W         = 16;
  localparam int         RESET_NS     = 320;
  localparam int         CLK_MHZ      = 50;
  localparam int         RESET_CYC    = (RESET_NS * CLK_MHZ + 999) / 1000;

  //==========================================================================
  // Core-side decode report
  typedef struct packed {
    logic            op_valid;
    logic [7:0]      opcode;
    logic            pc_valid;
    logic [PC_W-1:0] pc;
  } ocddc_core_s;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_RESET = 2'b10
  } ocddc_state_e;

endpackage

// ===== verilog/ocddc_top.sv
/*
  On-chip debug control: halt, resume, breakpoint handling, debug acknowledge
  and software-driven device reset, reached over APB.
  Assumes the core reports each decoded opcode and its PC as a one-cycle
  pulse on pclk, and the serial link takes the acknowledge byte by handshake.
  Limitation: the zero-count break bit is stored and read back only; it has
  no effect. Breakpoints are ignored while the core is halted or the device
  is in reset, so a halted core cannot re-trigger its own acknowledge.
*/
module ocddc_top #(
  parameter int RESET_CYCLES = ocddc_pkg::RESET_CYC
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Core side
  input  wire ocddc_pkg::ocddc_core_s  core_in,
  input  wire logic                    read_protect,
  output logic                         core_halt,
  output logic                         core_loop,
  output logic                         device_reset,
  // Acknowledge character towards the serial link
  output logic                         ack_valid,
  output logic      [7:0]              ack_byte,
  input  wire logic                    ack_ready
);

  //==========================================================================
  // Elaboration check: the reset counter is 16 bits wide, and the pulse
  // check below expects the reset to span two cycles at least
  if (RESET_CYCLES < 2 || RESET_CYCLES > 65535) begin : bad_reset_len_g
    $error("RESET_CYCLES out of range");
  end

  //==========================================================================
  // State
  logic [7:0]                  ctrl_r,    ctrl_nxt;
  logic [ocddc_pkg::PC_W-1:0]  cnt_r,     cnt_nxt;
  logic                        loop_r,    loop_nxt;
  logic                        ackv_r,    ackv_nxt;
  logic [7:0]                  ackb_r,    ackb_nxt;
  logic [31:0]                 rdata_r,   rdata_nxt;
  logic                        ready_r,   ready_nxt;
  logic                        err_r,     err_nxt;
  logic [15:0]                 rcnt_r,    rcnt_nxt;
  ocddc_pkg::ocddc_state_e     state_r,   state_nxt;

  logic setup, wr_ctl, wr_cnt, rst_busy, brk_evt, pc_hit, brk_seen;

  // Address decode shared by error flag and assertions; the read mux decodes paddr itself
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ocddc_pkg::ADDR_CTRL) || (a == ocddc_pkg::ADDR_COUNTER) ||
             (a == ocddc_pkg::ADDR_STATUS);
  endfunction

  //==========================================================================
  // Event decode
  always_comb begin
    setup    = psel & ~penable;
    wr_ctl   = psel & penable & ready_r & pwrite & (paddr == ocddc_pkg::ADDR_CTRL);
    wr_cnt   = psel & penable & ready_r & pwrite & (paddr == ocddc_pkg::ADDR_COUNTER);
    rst_busy = (state_r == ocddc_pkg::ST_RESET);
    // Disabled breakpoints leave the opcode to the core as a no-op
    brk_seen = core_in.op_valid & (core_in.opcode == ocddc_pkg::BRK_OPCODE) &
               ~ctrl_r[ocddc_pkg::BIT_HALT] & ~rst_busy;
    brk_evt  = brk_seen & ctrl_r[ocddc_pkg::BIT_BRK_EN];
    // Hardware breakpoint is ignored while halted or in reset
    pc_hit   = core_in.pc_valid & ctrl_r[ocddc_pkg::BIT_PC_MATCH] & (core_in.pc == cnt_r) &
               ~ctrl_r[ocddc_pkg::BIT_HALT] & ~rst_busy;
  end

  //==========================================================================
  // Control register, loop hold and reset sequencer next values
  always_comb begin
    ctrl_nxt  = ctrl_r;
    loop_nxt  = loop_r;
    state_nxt = state_r;
    rcnt_nxt  = rcnt_r;
    cnt_nxt   = wr_cnt ? pwdata[ocddc_pkg::PC_W-1:0] : cnt_r;
    if (wr_ctl) begin
      ctrl_nxt[ocddc_pkg::BIT_BRK_EN:ocddc_pkg::BIT_ZERO_CNT] =
        pwdata[ocddc_pkg::BIT_BRK_EN:ocddc_pkg::BIT_ZERO_CNT];
      ctrl_nxt[ocddc_pkg::BIT_RST]   = 1'b0;
      if (pwdata[ocddc_pkg::BIT_RST]) begin
        // A device reset is the one path allowed to drop halt under protection
        ctrl_nxt[ocddc_pkg::BIT_HALT] = pwdata[ocddc_pkg::BIT_HALT];
        state_nxt = ocddc_pkg::ST_RESET;
        rcnt_nxt  = 16'(RESET_CYCLES - 1);
        loop_nxt  = 1'b0;
      end else if (pwdata[ocddc_pkg::BIT_HALT]) begin
        ctrl_nxt[ocddc_pkg::BIT_HALT] = 1'b1;
      end else if (!read_protect) begin
        ctrl_nxt[ocddc_pkg::BIT_HALT] = 1'b0;
      end
    end
    // Loop hold ends when halted or when looping is deselected
    if (ctrl_nxt[ocddc_pkg::BIT_HALT] || !ctrl_nxt[ocddc_pkg::BIT_LOOP_SEL]) begin
      loop_nxt = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    if ((brk_evt && !ctrl_r[ocddc_pkg::BIT_LOOP_SEL]) || pc_hit) begin
      ctrl_nxt[ocddc_pkg::BIT_HALT] = 1'b1;
      loop_nxt = 1'b0;
    end else if (brk_evt && !ctrl_nxt[ocddc_pkg::BIT_HALT] &&
                 ctrl_nxt[ocddc_pkg::BIT_LOOP_SEL]) begin
      loop_nxt = 1'b1;
    end
    // Reset sequencer: counts the pulse down, then drops back to idle
    case (state_r)
      ocddc_pkg::ST_IDLE: begin
      end
      ocddc_pkg::ST_RESET: begin
        if (rcnt_r == 16'h0000) begin
          state_nxt = ocddc_pkg::ST_IDLE;
        end else begin
          rcnt_nxt = rcnt_r - 16'h0001;
        end
      end
      default: begin
        state_nxt = ocddc_pkg::ST_IDLE;
      end
    endcase
  end

  //==========================================================================
  // Acknowledge character: pending until the link takes it
  always_comb begin
    ackv_nxt = ackv_r;
    ackb_nxt = ackb_r;
    if (ackv_r && ack_ready) begin
      ackv_nxt = 1'b0;
    end
    // Set wins over a same-cycle take, so a new breakpoint is never lost
    if (brk_evt && ctrl_r[ocddc_pkg::BIT_ACK_EN]) begin
      ackv_nxt = 1'b1;
      ackb_nxt = ocddc_pkg::ACK_CHAR;
    end
  end

  //==========================================================================
  // APB answer: data prepared in setup, ready in the first access cycle
  always_comb begin
    ready_nxt = setup;
    err_nxt   = setup & ~mapped(paddr);
    rdata_nxt = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        ocddc_pkg::ADDR_CTRL:    rdata_nxt = {24'h00_0000, ctrl_r[7:2], 1'b0, rst_busy};
        ocddc_pkg::ADDR_COUNTER: rdata_nxt = 32'(cnt_r);
        ocddc_pkg::ADDR_STATUS:  rdata_nxt = {28'h000_0000, rst_busy, ackv_r, loop_r,
                                              ctrl_r[ocddc_pkg::BIT_HALT]};
        default:                 rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  //==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= ocddc_pkg::CTRL_RESET;
      cnt_r   <= '0;
      loop_r  <= 1'b0;
      ackv_r  <= 1'b0;
      ackb_r  <= 8'h00;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
      rcnt_r  <= 16'h0000;
      state_r <= ocddc_pkg::ST_IDLE;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cnt_r   <= cnt_nxt;
      loop_r  <= loop_nxt;
      ackv_r  <= ackv_nxt;
      ackb_r  <= ackb_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
      rcnt_r  <= rcnt_nxt;
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flops; device_reset is decoded from state_r
  always_comb begin
    prdata       = rdata_r;
    pready       = ready_r;
    pslverr      = err_r;
    core_halt    = ctrl_r[ocddc_pkg::BIT_HALT];
    core_loop    = loop_r;
    device_reset = rst_busy;
    ack_valid    = ackv_r;
    ack_byte     = ackb_r;
  end

  //==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Core side idle: no decode report this cycle
  logic quiet;
  assign quiet = ~core_in.op_valid & ~core_in.pc_valid;

  stop81_a: assert property (wr_ctl && pwdata[7:0] == 8'h81 |=>
    device_reset && core_halt) else $error("81H did not reset and halt");
  // A PC match in the same cycle halts the core, as does a breakpoint opcode unless looping was selected, and that set wins over go
  go41_a: assert property (wr_ctl && pwdata[7:0] == 8'h41 && !brk_evt && !pc_hit |=>
    device_reset && !core_halt) else $error("41H did not reset and run");
  run40_a: assert property (wr_ctl && pwdata[7:0] == 8'h40 && core_halt &&
    !read_protect |=> !core_halt) else $error("40H did not resume");
  halt_set_a: assert property (wr_ctl && pwdata[7] |=> core_halt)
    else $error("halt bit write ignored");
  halt_clr_a: assert property (wr_ctl && !pwdata[7] && !read_protect && quiet
    |=> !core_halt) else $error("halt clear ignored");
  brk_halt_a: assert property (brk_evt && !ctrl_r[4] |=> core_halt && !core_loop)
    else $error("breakpoint did not halt");
  protect_a: assert property (core_halt && read_protect && !(wr_ctl && pwdata[0])
    |=> core_halt) else $error("protected halt cleared");
  nop_a: assert property (brk_seen && !ctrl_r[6] && !wr_ctl && !pc_hit
    |=> $stable(core_halt) && (!ack_valid || $past(ack_valid)))
    else $error("disabled break acted");
  loop_a: assert property (brk_evt && ctrl_r[4] && !pc_hit && !wr_ctl
    |=> core_loop && !core_halt) else $error("loop select not honoured");
  ack_a: assert property (brk_evt && ctrl_r[5] |=> ack_valid && ack_byte == 8'hFF)
    else $error("acknowledge not raised");
  loop_sel_a: assert property (brk_evt && !ctrl_r[4] |-> ##1 !core_loop [*2])
    else $error("loop when halt selected");
  pc_a: assert property (pc_hit |=> core_halt)
    else $error("pc match did not halt");
  rst_len_a: assert property (wr_ctl && pwdata[0] |=> device_reset [*2])
    else $error("reset pulse too short");

  // Reset pulse length, counted so that a long default needs no long repetition
  logic [16:0] rst_len_r, rst_len_nxt;
  always_comb begin
    rst_len_nxt = rst_len_r;
    if (wr_ctl && pwdata[ocddc_pkg::BIT_RST]) begin
      rst_len_nxt = 17'h0_0000;
    end else if (rst_busy) begin
      rst_len_nxt = rst_len_r + 17'h0_0001;
    end
  end
  // Helper register for the pulse length check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_len_r <= 17'h0_0000;
    end else begin
      rst_len_r <= rst_len_nxt;
    end
  end
  rst_end_a: assert property ($fell(device_reset) |-> rst_len_r == 17'(RESET_CYCLES))
    else $error("reset pulse length wrong");

  // One answer per setup, one cycle long, so a held access cannot commit twice
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_one_a: assert property (psel && penable && pready |=> !pready)
    else $error("pready held for two cycles");
  err_map_a: assert property (psel && !penable && !mapped(paddr) |=> pslverr && pready)
    else $error("unmapped address not refused");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rd_zero_a: assert property (psel && !penable && !pwrite && !mapped(paddr) |=> prdata == '0)
    else $error("unmapped read not zero");

  // A pending character leaves only through the handshake, and is always FFH
  ack_hold_a: assert property (ack_valid && !ack_ready |=> ack_valid)
    else $error("acknowledge dropped before taken");
  ack_char_a: assert property (ack_valid |-> ack_byte == ocddc_pkg::ACK_CHAR)
    else $error("acknowledge character wrong");

  // Halt and loop never stand together; the loop hold gives way to halt
  halt_loop_a: assert property (core_halt |-> !core_loop)
    else $error("halted while looping");
  loop_drop_a: assert property (wr_ctl && !pwdata[ocddc_pkg::BIT_LOOP_SEL]
    |=> !core_loop) else $error("loop kept after deselect");

  // Breakpoints are not seen while the device sits in reset
  rst_quiet_a: assert property (device_reset && !core_halt && !wr_ctl |=> !core_halt)
    else $error("halt set during reset");
  cnt_keep_a: assert property (!wr_cnt |=> $stable(cnt_r))
    else $error("counter changed without a write");

  // Main scenarios reached
  cov_stop_c:  cover property (wr_ctl && pwdata[7:0] == 8'h81 ##[1:40] !device_reset);
  cov_brk_c:   cover property (brk_evt && ctrl_r[5] ##[1:10] (ack_valid && ack_ready));
  cov_loop_c:  cover property (brk_evt && ctrl_r[4]);
  cov_pc_c:    cover property (pc_hit);
  cov_prot_c:  cover property (core_halt && read_protect && wr_ctl && !pwdata[7]);

endmodule

// ===== test/ocddc_host_model.sv
/*
  Debug host model: takes acknowledge characters from the debug block.
  Assumes the same clock as the block and a testbench-driven stall input.
*/
module ocddc_host_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Acknowledge link
  input  wire logic       ack_valid,
  input  wire logic [7:0] ack_byte,
  input  wire logic       stall,
  output logic            ack_ready,
  // Received characters
  output logic [7:0]      rx_byte,
  output logic [7:0]      rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  //==========================================================================
  // Ready one cycle after an offer; stall models a slow host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ready <= 1'b0;
      rx_byte   <= 8'h00;
      rx_count  <= 8'h00;
    end else begin
      ack_ready <= ack_valid && !stall && !ack_ready;
      if (ack_valid && ack_ready) begin
        rx_byte  <= ack_byte;
        rx_count <= rx_count + 8'h01;
      end
    end
  end
endmodule

// ===== test/testbench.sv
/*
  Self-checking bench for the debug control block over APB.
  Assumes the host model on the acknowledge link and a two-cycle device reset;
  bus waits end only at the cycle ceiling.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]            paddr, ack_byte, rx_byte, rx_count;
  logic [31:0]           pwdata, prdata;
  ocddc_pkg::ocddc_core_s core_in;
  logic                  read_protect, core_halt, core_loop, device_reset;
  logic                  ack_valid, ack_ready, stall;
  int                    miscompares, n_tests, cycles;

  ocddc_top #(.RESET_CYCLES(2)) i_ocddc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_in(core_in), .read_protect(read_protect),
    .core_halt(core_halt), .core_loop(core_loop), .device_reset(device_reset),
    .ack_valid(ack_valid), .ack_byte(ack_byte), .ack_ready(ack_ready));
  ocddc_host_model i_ocddc_host_model (.pclk(pclk), .presetn(presetn),
    .ack_valid(ack_valid), .ack_byte(ack_byte), .stall(stall), .ack_ready(ack_ready),
    .rx_byte(rx_byte), .rx_count(rx_count));

  //==========================================================================
  // Clock, and a cycle ceiling so a hang still ends in the report
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  //==========================================================================
  // Compare, report and close
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  //==========================================================================
  // APB transfer: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
    @(posedge pclk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    chk(rd, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask
  // Core decode pulse; outputs answer one cycle after it is taken
  task automatic evt(input logic opv, input logic [7:0] op, input logic pcv,
                     input logic [15:0] pc);
    @(posedge pclk);
    core_in <= '{opv, op, pcv, pc};
    @(posedge pclk);
    core_in <= '0;
    @(posedge pclk);
    #1;
  endtask
  // Device reset: must start, then end within a bounded wait
  task automatic rst_wait();
    int n;
    n = 0;
    while (device_reset !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, device_reset}, 32'h0000_0001);
    while (device_reset === 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    #1;
    chk({31'h0, device_reset}, 32'h0000_0000);
  endtask

  //==========================================================================
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; core_in = '0; read_protect = 1'b0; stall = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ocddc_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    rdchk(ocddc_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
    rdchk(8'h0C, 32'h0000_0000, 1'b1);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0081);
    rst_wait();
    chk({31'h0, core_halt}, 32'h0000_0001);
    rdchk(ocddc_pkg::ADDR_CTRL, 32'h0000_0080, 1'b0);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0040);
    chk({31'h0, core_halt}, 32'h0000_0000);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0000);
    evt(1'b1, 8'h00, 1'b0, 16'h0000);
    chk({30'h0, core_halt, core_loop}, 32'h0000_0000);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0040);
    evt(1'b1, 8'h01, 1'b0, 16'h0000);
    chk({31'h0, core_halt}, 32'h0000_0000);
    stall <= 1'b1;
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0060);
    evt(1'b1, 8'h00, 1'b0, 16'h0000);
    chk({30'h0, core_halt, core_loop}, 32'h0000_0002);
    chk({23'h0, ack_valid, ack_byte}, 32'h0000_01FF);
    repeat (4) @(posedge pclk);
    chk({31'h0, ack_valid}, 32'h0000_0001);
    stall <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({15'h0, ack_valid, rx_byte, rx_count}, 32'h0000_FF01);
    rdchk(ocddc_pkg::ADDR_STATUS, 32'h0000_0001, 1'b0);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0050);
    chk({31'h0, core_halt}, 32'h0000_0000);
    evt(1'b1, 8'h00, 1'b0, 16'h0000);
    chk({30'h0, core_halt, core_loop}, 32'h0000_0001);
    wr(ocddc_pkg::ADDR_COUNTER, 32'h0000_1234);
    rdchk(ocddc_pkg::ADDR_COUNTER, 32'h0000_1234, 1'b0);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0008);
    evt(1'b0, 8'h00, 1'b1, 16'h1233);
    chk({31'h0, core_halt}, 32'h0000_0000);
    evt(1'b0, 8'h00, 1'b1, 16'h1234);
    chk({31'h0, core_halt}, 32'h0000_0001);
    @(posedge pclk);
    read_protect <= 1'b1;
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0008);
    chk({31'h0, core_halt}, 32'h0000_0001);
    wr(ocddc_pkg::ADDR_CTRL, 32'h0000_0041);
    rst_wait();
    chk({31'h0, core_halt}, 32'h0000_0000);
    rdchk(ocddc_pkg::ADDR_CTRL, 32'h0000_0040, 1'b0);
    // Mid-run reset: halt, loop, device reset, acknowledge valid and the control register return to zero
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk({28'h0, core_halt, core_loop, device_reset, ack_valid}, 32'h0000_0000);
    rdchk(ocddc_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    results();
  end
endmodule
